// File: logic/rgp_pkg.sv
// Purpose: Shared constants and types for the tri-speed RGMII block
// Assumes: 125 MHz transmit reference, 4-bit DDR link
// Notes:   Speed codes are driven by the MAC's speed control logic

package rgp_pkg;

    // ----------------------------------------------------------------
    // Link speed
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        RGP_SPD_10   = 2'b00,
        RGP_SPD_100  = 2'b01,
        RGP_SPD_1000 = 2'b10
    } rgp_speed_e;

    // ----------------------------------------------------------------
    // Transmit clock enable divisors and forwarded-clock timing
    // ----------------------------------------------------------------
    localparam int          RGP_TX_REF_MHZ    = 125;
    localparam int          RGP_DIV_100       = 10;
    localparam int          RGP_DIV_10        = 100;
    localparam int          RGP_CNT_W         = 6;
    localparam logic [5:0]  RGP_HALF_100      = 6'(RGP_DIV_100 / 2);
    localparam logic [5:0]  RGP_HALF_10       = 6'(RGP_DIV_10 / 2);
    localparam logic [5:0]  RGP_CNT_RST       = 6'h00;
    // Clock lags data by a quarter reference period
    localparam int          RGP_TXC_OFFSET_PS = 2000;
    localparam int          RGP_REF_PERIOD_PS = 1000000 / RGP_TX_REF_MHZ;
    localparam int          RGP_QUAD_PHASE_DEG =
        (RGP_TXC_OFFSET_PS * 360) / RGP_REF_PERIOD_PS;

    // ----------------------------------------------------------------
    // DDR pad bundles: rise half and fall half of one clock period
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [3:0] d_rise;
        logic [3:0] d_fall;
        logic       ctl_rise;
        logic       ctl_fall;
    } rgp_ddr_s;

    localparam rgp_ddr_s RGP_DDR_RST = '0;

endpackage : rgp_pkg

// File: logic/rgp_phy_if.sv
// Purpose: Tri-speed RGMII physical interface between MAC and PHY
// Assumes: core_clk is the 125 MHz transmit reference; the quadrature
//          clock is the same reference shifted 90 degrees
// Notes:   DDR pad cells sit outside; this block fills their halves
//
// Operation
// - One reference clock for transmit data, control and enable logic
// - Enable always, one in ten, or hundred
// - Transmit enable delivered to MAC level
// - Handshake throttles stream to link rate
// - Transmit data and control in DDR registers
// - Forwarded clock from same DDR register kind
// - Forwarded clock lags data by 2 ns
// - Quadrature reference clocks forwarded-clock register
// - Slow speeds toggle clock register inputs
// - Receive clock samples pads, clocks receive logic
// - Receive enable paces receive stream
// - Transmit clocks shared, receive clock per instance
// - Link carries 10/100/1000 via DDR

`timescale 1ns/1ps
`default_nettype none

module rgp_phy_if (
    input  wire logic              core_clk,       // 125 MHz reference
    input  wire logic              tx_reference_clock_quadrature, // +90 deg
    input  wire logic              rx_clk,         // PHY receive clock
    input  wire logic              rst,            // Sync reset, core
    input  wire rgp_pkg::rgp_speed_e speed,        // Link speed, core
    output logic                   tx_enable_q,    // Transmit clock enable
    input  wire logic [7:0]        tx_tdata,       // Transmit byte
    input  wire logic              tx_tvalid,      // Transmit byte valid
    input  wire logic              tx_tuser,       // Transmit error
    output logic                   tx_tready_q,    // Transmit accept
    output rgp_pkg::rgp_ddr_s      tx_pad_q,       // Data/ctl DDR halves
    output logic                   txc_rise_q,     // Fwd clock rise half
    output logic                   txc_fall_q,     // Fwd clock fall half
    input  wire rgp_pkg::rgp_ddr_s rx_pad,         // Receive DDR halves
    output logic                   rx_enable_q,    // Receive clock enable
    output logic [7:0]             rx_tdata_q,     // Received byte
    output logic                   rx_tvalid_q,    // Received byte valid
    output logic                   rx_tuser_q      // Received error
);
    import rgp_pkg::*;

    // ----------------------------------------------------------------
    // Decoding
    // ----------------------------------------------------------------
    function automatic logic is_gig(input rgp_speed_e s);
        is_gig = (s == RGP_SPD_1000);
    endfunction : is_gig

    function automatic logic [5:0] half_len(input rgp_speed_e s);
        case (s)
            RGP_SPD_100: half_len = RGP_HALF_100;
            RGP_SPD_10:  half_len = RGP_HALF_10;
            default:     half_len = 6'h01;
        endcase
    endfunction : half_len

    // ----------------------------------------------------------------
    // Transmit enable generator
    // ----------------------------------------------------------------
    logic [5:0] cnt_q;
    logic [5:0] cnt_d;
    logic       hi_q;
    logic       hi_d;
    logic       tx_gig;
    logic [5:0] tx_half;

    assign tx_gig  = is_gig(speed);
    assign tx_half = half_len(speed);

    always_comb begin
        cnt_d = cnt_q;
        hi_d  = hi_q;
        if (tx_gig) begin
            cnt_d = RGP_CNT_RST;
            hi_d  = 1'b0;
        end else if (cnt_q >= tx_half - 6'h01) begin
            cnt_d = RGP_CNT_RST;
            hi_d  = ~hi_q;
        end else begin
            cnt_d = cnt_q + 6'h01;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            cnt_q <= RGP_CNT_RST;
            hi_q  <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            hi_q  <= hi_d;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            tx_enable_q <= 1'b0;
            tx_tready_q <= 1'b0;
        end else begin
            tx_enable_q <= tx_gig |
                (hi_d && cnt_d == tx_half - 6'h01);
            tx_tready_q <= tx_gig |
                (hi_d && cnt_d == tx_half - 6'h01);
        end
    end

    // ----------------------------------------------------------------
    // Transmit byte holding
    // ----------------------------------------------------------------
    logic [7:0] byte_q;
    logic [7:0] byte_d;
    logic       act_q;
    logic       act_d;
    logic       err_q;
    logic       err_d;
    logic       tx_take;

    assign tx_take = tx_tready_q & tx_tvalid;

    always_comb begin
        byte_d = byte_q;
        act_d  = act_q;
        err_d  = err_q;
        if (tx_tready_q) begin
            act_d = tx_tvalid;
            err_d = tx_tvalid & tx_tuser;
            if (tx_take) begin
                byte_d = tx_tdata;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            byte_q <= 8'h00;
            act_q  <= 1'b0;
            err_q  <= 1'b0;
        end else begin
            byte_q <= byte_d;
            act_q  <= act_d;
            err_q  <= err_d;
        end
    end

    // ----------------------------------------------------------------
    // Transmit DDR data and control registers
    // ----------------------------------------------------------------
    // DDR pad capture
    always_ff @(posedge core_clk) begin
        if (rst) begin
            tx_pad_q <= RGP_DDR_RST;
        end else if (tx_gig) begin
            tx_pad_q.d_rise   <= byte_d[3:0];
            tx_pad_q.d_fall   <= byte_d[7:4];
            tx_pad_q.ctl_rise <= act_d;
            tx_pad_q.ctl_fall <= act_d ^ err_d;
        end else begin
            tx_pad_q.d_rise   <= hi_d ? byte_d[7:4] : byte_d[3:0];
            tx_pad_q.d_fall   <= hi_d ? byte_d[7:4] : byte_d[3:0];
            tx_pad_q.ctl_rise <= act_d;
            tx_pad_q.ctl_fall <= act_d ^ err_d;
        end
    end

    // ----------------------------------------------------------------
    // Forwarded clock, quadrature domain
    // ----------------------------------------------------------------
    // The quadrature clock is the reference itself delayed a quarter
    // period, so core flops are stable when it samples them; it sees
    // the state that the data pads took on the preceding core edge.
    logic       q_rst_m;
    logic       q_rst_q;
    logic [6:0] txc_pos;

    always_ff @(posedge tx_reference_clock_quadrature) begin
        q_rst_m <= rst;
        q_rst_q <= q_rst_m;
    end

    assign txc_pos = {cnt_q, 1'b0};

    always_ff @(posedge tx_reference_clock_quadrature) begin
        if (q_rst_q) begin
            txc_rise_q <= 1'b0;
            txc_fall_q <= 1'b0;
        end else if (tx_gig) begin
            txc_rise_q <= 1'b1;
            txc_fall_q <= 1'b0;
        end else begin
            txc_rise_q <= txc_pos < {1'b0, tx_half};
            txc_fall_q <= (txc_pos + 7'h01) < {1'b0, tx_half};
        end
    end

    // ----------------------------------------------------------------
    // Receive domain crossings
    // ----------------------------------------------------------------
    // receive clock is this instance's own
    logic       r_rst_m;
    logic       r_rst_q;
    rgp_speed_e r_spd_m;
    rgp_speed_e r_spd_s;
    rgp_speed_e r_spd_c;
    rgp_speed_e r_spd_q;

    always_ff @(posedge rx_clk) begin
        r_rst_m <= rst;
        r_rst_q <= r_rst_m;
    end

    // Code bits may skew in flight; only a code held two edges is taken
    always_ff @(posedge rx_clk) begin
        r_spd_m <= speed;
        r_spd_s <= r_spd_m;
        r_spd_c <= r_spd_s;
        if (r_spd_s == r_spd_c) begin
            r_spd_q <= r_spd_c;
        end
    end

    // ----------------------------------------------------------------
    // Receive pad sampling
    // ----------------------------------------------------------------
    rgp_ddr_s rx_pad_q;

    always_ff @(posedge rx_clk) begin
        if (r_rst_q) begin
            rx_pad_q <= RGP_DDR_RST;
        end else begin
            rx_pad_q <= rx_pad;
        end
    end

    // ----------------------------------------------------------------
    // Receive byte assembly and pacing
    // ----------------------------------------------------------------
    logic       r_dv;
    logic       r_er;
    logic       r_half_q;
    logic [3:0] r_low_q;
    logic       r_lerr_q;

    assign r_dv = rx_pad_q.ctl_rise;
    assign r_er = rx_pad_q.ctl_rise ^ rx_pad_q.ctl_fall;

    always_ff @(posedge rx_clk) begin
        if (r_rst_q) begin
            r_half_q    <= 1'b0;
            r_low_q     <= 4'h0;
            r_lerr_q    <= 1'b0;
            rx_enable_q <= 1'b0;
            rx_tdata_q  <= 8'h00;
            rx_tvalid_q <= 1'b0;
            rx_tuser_q  <= 1'b0;
        end else if (is_gig(r_spd_q)) begin
            r_half_q    <= 1'b0;
            rx_enable_q <= 1'b1;
            rx_tdata_q  <= {rx_pad_q.d_fall, rx_pad_q.d_rise};
            rx_tvalid_q <= r_dv;
            rx_tuser_q  <= r_dv & r_er;
        end else if (!r_dv) begin
            r_half_q    <= 1'b0;
            rx_enable_q <= 1'b0;
            rx_tvalid_q <= 1'b0;
            rx_tuser_q  <= 1'b0;
        end else if (!r_half_q) begin
            r_half_q    <= 1'b1;
            r_low_q     <= rx_pad_q.d_rise;
            r_lerr_q    <= r_er;
            rx_enable_q <= 1'b0;
            rx_tvalid_q <= 1'b0;
            rx_tuser_q  <= 1'b0;
        end else begin
            r_half_q    <= 1'b0;
            rx_enable_q <= 1'b1;
            rx_tdata_q  <= {rx_pad_q.d_rise, r_low_q};
            rx_tvalid_q <= 1'b1;
            rx_tuser_q  <= r_lerr_q | r_er;
        end
    end

endmodule : rgp_phy_if

`default_nettype wire

// File: tb/rgp_phy_if_checker.sv
// Purpose: Port assertions for the tri-speed RGMII block
// Assumes: Speed changes only while reset is high
// Notes:   Bound to every instance of the block
`timescale 1ns/1ps
`default_nettype none
module rgp_phy_if_checker (
    input wire logic                core_clk,    // Reference
    input wire logic                rx_clk,      // Rx clock
    input wire logic                rst,         // Reset
    input wire rgp_pkg::rgp_speed_e speed,       // Speed
    input wire logic                tx_enable_q, // Tx enable
    input wire logic                tx_tready_q, // Tx ready
    input wire logic [7:0]          tx_tdata,    // Tx byte
    input wire logic                tx_tvalid,   // Tx valid
    input wire logic                tx_tuser,    // Tx error
    input wire rgp_pkg::rgp_ddr_s   tx_pad_q,    // Pad halves
    input wire logic                txc_rise_q,  // Clock rise
    input wire logic                txc_fall_q,  // Clock fall
    input wire logic                rx_enable_q, // Rx enable
    input wire logic                rx_tvalid_q  // Rx valid
);
    import rgp_pkg::*;
    logic [6:0] gap_q;
    logic       seen_q;
    logic [2:0] up_q;
    logic [8:0] acc_q;
    wire logic  take = tx_tready_q && tx_tvalid;
    // ----
    // Helpers
    // ----
    always_ff @(posedge core_clk) begin
        if (rst || tx_enable_q) begin
            gap_q <= 7'h00;
        end else begin
            gap_q <= gap_q + 7'h01;
        end
        seen_q <= !rst && (seen_q || tx_enable_q);
    end
    // Quad outputs lag reset release by two edges
    always_ff @(posedge core_clk) begin
        if (rst) begin
            up_q <= 3'h0;
        end else if (up_q != 3'h7) begin
            up_q <= up_q + 3'h1;
        end
    end
    always_ff @(posedge core_clk) begin
        if (take) begin
            acc_q <= {tx_tuser, tx_tdata};
        end
    end
    sequence lo_s;
        (tx_pad_q.d_rise == acc_q[3:0] && tx_pad_q.d_fall == acc_q[3:0])[*5];
    endsequence
    sequence hi_s;
        tx_pad_q.d_rise == acc_q[7:4] && tx_pad_q.d_fall == acc_q[7:4];
    endsequence
    a_gig_en: assert property (@(posedge core_clk)
        disable iff (rst) speed == RGP_SPD_1000 && up_q == 3'h7 |-> tx_enable_q)
        else $error("enable low at gigabit");
    a_ready_tracks: assert property (@(posedge core_clk)
        disable iff (rst) tx_tready_q == tx_enable_q)
        else $error("ready differs from enable");
    a_gap_100: assert property (@(posedge core_clk)
        disable iff (rst) speed == RGP_SPD_100 && tx_enable_q && seen_q
        |-> gap_q == 7'h09)
        else $error("enable spacing wrong at 100");
    a_gap_10: assert property (@(posedge core_clk)
        disable iff (rst) speed == RGP_SPD_10 && tx_enable_q && seen_q
        |-> gap_q == 7'h63)
        else $error("enable spacing wrong at 10");
    a_pad_low: assert property (@(posedge core_clk)
        disable iff (rst) take |=> tx_pad_q.d_rise == acc_q[3:0]
        && tx_pad_q.ctl_rise && tx_pad_q.ctl_fall != acc_q[8])
        else $error("pad low nibble or control wrong");
    a_gig_high: assert property (@(posedge core_clk)
        disable iff (rst) speed == RGP_SPD_1000 && take
        |=> tx_pad_q.d_fall == acc_q[7:4])
        else $error("pad high nibble wrong");
    a_slow_order: assert property (@(posedge core_clk)
        disable iff (rst) speed == RGP_SPD_100 && take |=> lo_s ##1 hi_s)
        else $error("nibble order wrong at 100");
    a_gig_txc: assert property (@(posedge core_clk)
        disable iff (rst) speed == RGP_SPD_1000 && up_q == 3'h7
        |-> txc_rise_q && !txc_fall_q)
        else $error("forwarded clock halves wrong");
    a_rx_valid_en: assert property (@(posedge rx_clk)
        disable iff (rst) rx_tvalid_q |-> rx_enable_q)
        else $error("rx valid without enable");
    a_rx_pulse: assert property (@(posedge rx_clk)
        disable iff (rst) speed != RGP_SPD_1000 && rx_tvalid_q |=> !rx_tvalid_q)
        else $error("rx valid longer than one cycle");
endmodule : rgp_phy_if_checker
bind rgp_phy_if rgp_phy_if_checker u_chk (.core_clk, .rx_clk, .rst, .speed,
    .tx_enable_q, .tx_tready_q, .tx_tdata, .tx_tvalid, .tx_tuser, .tx_pad_q,
    .txc_rise_q, .txc_fall_q, .rx_enable_q, .rx_tvalid_q);
`default_nettype wire

// File: tb/rgp_phy_model.sv
// Purpose: PHY receive side driving the RGMII pads
// Assumes: Receive clock runs only in reset and in receive scenarios
// Notes:   Idle data shows the inverse of the last nibble
`timescale 1ns/1ps
`default_nettype none
module rgp_phy_model (
    output logic                  rx_clk, // Rx clock
    output var rgp_pkg::rgp_ddr_s rx_pad  // Rx halves
);
    import rgp_pkg::*;
    initial begin
        rx_clk = 1'b0;
        rx_pad = RGP_DDR_RST;
    end
    task automatic put(input logic [3:0] r, input logic [3:0] f,
                       input logic c_r, input logic c_f);
        rx_pad = {r, f, c_r, c_f};
        #24 rx_clk = 1'b1;
        #24 rx_clk = 1'b0;
    endtask : put
    task automatic send(input logic [7:0] b, input logic err,
                        input logic gig);
        if (gig) begin
            put(b[3:0], b[7:4], 1'b1, ~err);
        end else begin
            put(b[3:0], b[3:0], 1'b1, ~err);
            put(b[7:4], b[7:4], 1'b1, ~err);
        end
    endtask : send
    // Toggling idle data so stale nibbles cannot pass
    task automatic idle(input int n);
        for (int i = 0; i < n; i++) begin
            put(~rx_pad.d_rise, ~rx_pad.d_fall, 1'b0, 1'b0);
        end
    endtask : idle
endmodule : rgp_phy_model
`default_nettype wire

// File: tb/rgp_phy_if_test.sv
// Purpose: Self-checking bench for the RGMII block
// Assumes: 10 MHz reference, 48 ns receive clock
// Notes:   Each scenario resets at its own speed
`timescale 1ns/1ps
`default_nettype none
module rgp_phy_if_test;
    import rgp_pkg::*;
    logic       core_clk  = 1'b0;
    logic       rst       = 1'b1;
    rgp_speed_e speed     = RGP_SPD_1000;
    logic [7:0] tx_tdata  = 8'h00;
    logic       tx_tvalid = 1'b0;
    logic       tx_tuser  = 1'b0;
    wire logic  quad_clk;
    wire logic  rx_clk;
    rgp_ddr_s   rx_pad;
    rgp_ddr_s   tx_pad_q;
    logic       tx_enable_q, tx_tready_q, txc_rise_q, txc_fall_q;
    logic       rx_enable_q, rx_tvalid_q, rx_tuser_q;
    logic [7:0] rx_tdata_q;
    logic [8:0] got[$];
    int         bad_count   = 0;
    int         check_count = 0;
    always #50 core_clk = ~core_clk;
    assign #25 quad_clk = core_clk;
    rgp_phy_if u_dut (.core_clk, .tx_reference_clock_quadrature(quad_clk),
        .rx_clk, .rst, .speed, .tx_enable_q, .tx_tdata, .tx_tvalid, .tx_tuser,
        .tx_tready_q, .tx_pad_q, .txc_rise_q, .txc_fall_q, .rx_pad,
        .rx_enable_q, .rx_tdata_q, .rx_tvalid_q, .rx_tuser_q);
    rgp_phy_model u_phy (.rx_clk, .rx_pad);
    always @(posedge rx_clk) begin
        if (rx_tvalid_q === 1'b1) begin
            got.push_back({rx_tuser_q, rx_tdata_q});
        end
    end
    task automatic chk(input logic [15:0] seen, input logic [15:0] want);
        check_count++;
        if (seen !== want) begin
            bad_count++;
            $display("Error at %0t: seen %0h expected %0h", $time, seen, want);
        end
    endtask : chk
    task automatic close_out;
        $display("Checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : close_out
    task automatic reset_to(input rgp_speed_e s);
        @(posedge core_clk);
        rst   <= 1'b1;
        speed <= s;
        fork
            repeat (12) @(posedge core_clk);
            u_phy.idle(8);
        join
        rst <= 1'b0;
        got.delete();
    endtask : reset_to
    // ----
    // Scenarios
    // ----
    task automatic tx_run(input rgp_speed_e s, input int gap);
        logic [7:0] b;
        logic [7:0] a;
        rgp_ddr_s   e;
        int         n;
        int         h;
        reset_to(s);
        b = 8'h5A;
        n = 0;
        tx_tdata  <= b;
        tx_tuser  <= b[0];
        tx_tvalid <= 1'b1;
        for (int i = 0; i < 3; i++) begin
            do begin
                @(posedge core_clk);
                n++;
            end while (tx_tready_q !== 1'b1 && n < 300);
            if (n >= 300) begin
                bad_count++;
                close_out();
            end
            a = b;
            e = {a[3:0], (gap == 1) ? a[7:4] : a[3:0], 1'b1, ~a[0]};
            b = b + 8'h37;
            tx_tdata <= b;
            tx_tuser <= b[0];
            #1;
            chk(16'(tx_pad_q), 16'(e));
            if (i > 0) chk(16'(n), 16'(gap));
            n = 0;
            if (gap > 1) begin
                // Forwarded clock: one period per nibble, half of it high
                h = 0;
                repeat (gap / 2) begin
                    @(posedge core_clk);
                    #30;
                    h += int'(txc_rise_q) + int'(txc_fall_q);
                end
                n = gap / 2;
                chk(16'(h), 16'(gap / 2));
                chk(16'({tx_pad_q.d_rise, tx_pad_q.d_fall}), {8'h00, a[7:4], a[7:4]});
            end
        end
        @(posedge core_clk);
        tx_tvalid <= 1'b0;
    endtask : tx_run
    task automatic rx_run(input rgp_speed_e s);
        reset_to(s);
        u_phy.idle(4);
        u_phy.send(8'hC3, 1'b0, s == RGP_SPD_1000);
        u_phy.send(8'h7E, 1'b1, s == RGP_SPD_1000);
        u_phy.idle(4);
        chk(16'(got.size()), 16'h0002);
        if (got.size() == 2) begin
            chk(16'(got[0]), 16'h00C3);
            chk(16'(got[1]), 16'h017E);
        end
    endtask : rx_run
    initial begin
        tx_run(RGP_SPD_1000, 1);
        tx_run(RGP_SPD_100, 10);
        tx_run(RGP_SPD_10, 100);
        rx_run(RGP_SPD_1000);
        rx_run(RGP_SPD_100);
        rx_run(RGP_SPD_10);
        close_out();
    end
endmodule : rgp_phy_if_test
`default_nettype wire
